// [lvc_consts.vh]
`ifndef LVC_CONSTS_VH
`define LVC_CONSTS_VH

// clock and software waits
`define LVC_CLK_PERIOD_NS   5
`define LVC_REF_WAIT_NS     2000000
`define LVC_ON_WAIT_NS      200000
`define LVC_WAIT_W          19

// device register map (byte addresses on the device bus)
`define LVC_DEV_AW          16
`define LVC_DEV_CTRL_ADDR   16'hffbe
`define LVC_DEV_LVL_ADDR    16'hffbf

// device detect_control_reg bit positions
`define LVC_DC_ENABLE       7
`define LVC_DC_REF          4
`define LVC_DC_MODE         1
`define LVC_DC_FLAG         0
`define LVC_BYTE_ZERO       8'h00

// level codes
`define LVC_LVL_PROHIBITED  3'h7
`define LVC_LVL_POC_FIRST   3'h4

// own apb register map
`define LVC_APB_AW          12
`define LVC_REG_CONFIG      12'h000
`define LVC_REG_COMMAND     12'h004
`define LVC_REG_STATUS      12'h008

// config fields
`define LVC_CFG_RESET       8'h00
`define LVC_CFG_LVL_HI      2
`define LVC_CFG_LVL_LO      0
`define LVC_CFG_MODE        3
`define LVC_CFG_POC         4
`define LVC_CFG_POC35       5
`define LVC_CFG_BYTESTOP    6

// command fields
`define LVC_CMD_START       0
`define LVC_CMD_STOP        1

// status fields
`define LVC_ST_BUSY         0
`define LVC_ST_RUN          1
`define LVC_ST_ERR          2
`define LVC_ST_FLAG         3
`define LVC_ST_EVENT        4
`define LVC_ST_SHADOW_LO    8

`endif

// [lvc_host.v]
`timescale 1ns/1ps
`include "lvc_consts.vh"

module lvc_host #(
  parameter REF_WAIT_CYC = `LVC_REF_WAIT_NS / `LVC_CLK_PERIOD_NS,
  parameter ON_WAIT_CYC  = `LVC_ON_WAIT_NS / `LVC_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire                    pclk,
  input  wire                    presetn,
  // apb slave
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [`LVC_APB_AW-1:0]  paddr,
  input  wire [31:0]             pwdata,
  output reg  [31:0]             prdata,
  output reg                     pready,
  output reg                     pslverr,
  // device byte bus, four-phase req/ack
  output reg                     dev_req,
  output reg                     dev_wr,
  output reg  [`LVC_DEV_AW-1:0]  dev_addr,
  output reg  [7:0]              dev_wdata,
  input  wire                    dev_ack,
  input  wire [7:0]              dev_rdata,
  // device interrupt pins
  output reg                     low_supply_irq_mask,
  output reg                     irq_req_clear,
  input  wire                    low_supply_irq_request
);

  // one-hot sequencer states
  localparam [13:0] S_IDLE  = 14'h0001;
  localparam [13:0] S_MASK  = 14'h0002;
  localparam [13:0] S_LVL   = 14'h0004;
  localparam [13:0] S_REF   = 14'h0008;
  localparam [13:0] S_WREF  = 14'h0010;
  localparam [13:0] S_ON    = 14'h0020;
  localparam [13:0] S_WON   = 14'h0040;
  localparam [13:0] S_POLL  = 14'h0080;
  localparam [13:0] S_CHK   = 14'h0100;
  localparam [13:0] S_MODE  = 14'h0200;
  localparam [13:0] S_CLRIF = 14'h0400;
  localparam [13:0] S_RUN   = 14'h0800;
  localparam [13:0] S_STOP  = 14'h1000;
  localparam [13:0] S_OP    = 14'h2000;

  localparam [`LVC_WAIT_W-1:0] REF_CNT = REF_WAIT_CYC[`LVC_WAIT_W-1:0];
  localparam [`LVC_WAIT_W-1:0] ON_CNT  = ON_WAIT_CYC[`LVC_WAIT_W-1:0];

  // level legal check, used only at start
  function lvl_ok;
    input [2:0] lvl;
    input       poc35;
    begin
      lvl_ok = (lvl != `LVC_LVL_PROHIBITED) && !(poc35 && (lvl >= `LVC_LVL_POC_FIRST));
    end
  endfunction

  // state and registers
  reg  [13:0]             state_q;     // sequencer state
  reg  [13:0]             ret_q;       // state after a bus op
  reg                     op_phase_q;  // 0 request, 1 release
  reg  [7:0]              cfg_q;       // software config
  reg  [7:0]              shadow_q;    // last control byte written
  reg  [`LVC_WAIT_W-1:0]  wait_q;      // software wait counter
  reg                     err_q;       // refused start
  reg                     flag_q;      // last flag read
  reg                     event_q;     // sticky request seen
  reg                     start_q;     // pending start
  reg                     stop_q;      // pending stop
  reg  [7:0]              rd_q;        // captured read byte
  reg  [1:0]              ack_s;       // ack synchroniser
  reg  [15:0]             rdat_s;      // read data synchroniser
  reg  [1:0]              irq_s;       // request synchroniser

  wire        apb_acc  = psel && penable && !pready;
  wire        apb_wr   = apb_acc && pwrite;
  wire        ack_in   = ack_s[1];
  wire [2:0]  lvl      = cfg_q[`LVC_CFG_LVL_HI:`LVC_CFG_LVL_LO];
  wire        irq_in   = irq_s[1];
  wire        st_clr   = apb_wr && (paddr == `LVC_REG_STATUS) && pwdata[`LVC_ST_EVENT];
  wire        run_irq  = (state_q == S_RUN) && !cfg_q[`LVC_CFG_MODE];

  // two-flop synchronisers for device inputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_s  <= 2'h0;
      rdat_s <= 16'h0000;
      irq_s  <= 2'h0;
    end else begin
      ack_s  <= {ack_s[0], dev_ack};
      rdat_s <= {rdat_s[7:0], dev_rdata};
      irq_s  <= {irq_s[0], low_supply_irq_request};
    end
  end

  // apb slave, one wait cycle, registered answer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      cfg_q   <= `LVC_CFG_RESET;
    end else begin
      pready  <= apb_acc;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (apb_acc) begin
        case (paddr)
          `LVC_REG_CONFIG: begin
            prdata <= {24'h000000, cfg_q};
            if (pwrite) begin
              cfg_q <= pwdata[7:0];
            end
          end
          `LVC_REG_COMMAND: begin
            prdata <= 32'h00000000;  // write only
          end
          `LVC_REG_STATUS: begin
            prdata <= {16'h0000, shadow_q, 3'h0, event_q, flag_q, err_q,
                       (state_q == S_RUN), (state_q != S_IDLE)};
          end
          default: begin
            pslverr <= 1'b1;  // unmapped
          end
        endcase
      end
    end
  end

  // sequencer: start, stop, service and device bus ops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q             <= S_IDLE;
      ret_q               <= S_IDLE;
      op_phase_q          <= 1'b0;
      shadow_q            <= `LVC_BYTE_ZERO;
      wait_q              <= {`LVC_WAIT_W{1'b0}};
      err_q               <= 1'b0;
      flag_q              <= 1'b0;
      event_q             <= 1'b0;
      start_q             <= 1'b0;
      stop_q              <= 1'b0;
      rd_q                <= 8'h00;
      dev_req             <= 1'b0;
      dev_wr              <= 1'b0;
      dev_addr            <= {`LVC_DEV_AW{1'b0}};
      dev_wdata           <= 8'h00;
      low_supply_irq_mask <= 1'b1;
      irq_req_clear       <= 1'b0;
    end else begin
      irq_req_clear <= 1'b0;
      // command pulses latch until taken
      if (apb_wr && (paddr == `LVC_REG_COMMAND)) begin
        start_q <= start_q | pwdata[`LVC_CMD_START];
        stop_q  <= stop_q | pwdata[`LVC_CMD_STOP];
      end
      // sticky request event, set beats clear
      if (run_irq && irq_in) begin
        event_q <= 1'b1;
      end else if (st_clr) begin
        event_q <= 1'b0;
      end
      case (state_q)
        S_IDLE: begin
          if (stop_q) begin
            stop_q  <= 1'b0;
            state_q <= S_STOP;
          end else if (start_q) begin
            start_q <= 1'b0;
            if (lvl_ok(lvl, cfg_q[`LVC_CFG_POC35])) begin
              err_q   <= 1'b0;
              state_q <= S_MASK;
            end else begin
              err_q <= 1'b1;
            end
          end
        end
        // start: mask first, then the level byte
        S_MASK: begin
          low_supply_irq_mask <= 1'b1;
          dev_wr    <= 1'b1;
          dev_addr  <= `LVC_DEV_LVL_ADDR;
          dev_wdata <= {5'h00, lvl};
          ret_q     <= cfg_q[`LVC_CFG_POC] ? S_ON : S_REF;
          state_q   <= S_OP;
        end
        // reference on, its settle wait loaded
        S_REF: begin
          shadow_q  <= shadow_q | (8'h01 << `LVC_DC_REF);
          dev_wr    <= 1'b1;
          dev_addr  <= `LVC_DEV_CTRL_ADDR;
          dev_wdata <= shadow_q | (8'h01 << `LVC_DC_REF);
          wait_q    <= REF_CNT;
          ret_q     <= S_WREF;
          state_q   <= S_OP;
        end
        // count down the reference settle time
        S_WREF: begin
          if (wait_q <= {{(`LVC_WAIT_W-1){1'b0}}, 1'b1}) begin
            state_q <= S_ON;
          end else begin
            wait_q <= wait_q - {{(`LVC_WAIT_W-1){1'b0}}, 1'b1};
          end
        end
        // detector on, flag wait loaded
        S_ON: begin
          shadow_q  <= shadow_q | (8'h01 << `LVC_DC_ENABLE);
          dev_wr    <= 1'b1;
          dev_addr  <= `LVC_DEV_CTRL_ADDR;
          dev_wdata <= shadow_q | (8'h01 << `LVC_DC_ENABLE);
          wait_q    <= ON_CNT;
          ret_q     <= S_WON;
          state_q   <= S_OP;
        end
        // count down before the flag is trusted
        S_WON: begin
          if (wait_q <= {{(`LVC_WAIT_W-1){1'b0}}, 1'b1}) begin
            state_q <= S_POLL;
          end else begin
            wait_q <= wait_q - {{(`LVC_WAIT_W-1){1'b0}}, 1'b1};
          end
        end
        // read the control byte for the flag
        S_POLL: begin
          dev_wr   <= 1'b0;
          dev_addr <= `LVC_DEV_CTRL_ADDR;
          ret_q    <= S_CHK;
          state_q  <= S_OP;
        end
        S_CHK: begin
          flag_q <= rd_q[`LVC_DC_FLAG];
          if (stop_q) begin
            stop_q  <= 1'b0;
            state_q <= S_STOP;
          end else if (rd_q[`LVC_DC_FLAG]) begin
            state_q <= S_POLL;  // supply still low
          end else if (cfg_q[`LVC_CFG_MODE]) begin
            state_q <= (shadow_q[`LVC_DC_MODE]) ? S_RUN : S_MODE;
          end else begin
            state_q <= S_CLRIF;
          end
        end
        // reset mode armed only once supply is high
        S_MODE: begin
          shadow_q  <= shadow_q | (8'h01 << `LVC_DC_MODE);
          dev_wr    <= 1'b1;
          dev_addr  <= `LVC_DEV_CTRL_ADDR;
          dev_wdata <= shadow_q | (8'h01 << `LVC_DC_MODE);
          ret_q     <= S_RUN;
          state_q   <= S_OP;
        end
        // clear the request first, unmask one cycle later
        S_CLRIF: begin
          if (!irq_req_clear && low_supply_irq_mask) begin
            irq_req_clear <= 1'b1;
          end else if (irq_req_clear) begin
            low_supply_irq_mask <= 1'b0;
            state_q             <= S_RUN;
          end else begin
            irq_req_clear <= 1'b1;
            state_q       <= S_RUN;
          end
        end
        // synced request lags its clear: one extra poll may follow
        S_RUN: begin
          if (stop_q) begin
            stop_q  <= 1'b0;
            state_q <= S_STOP;
          end else if (run_irq && irq_in) begin
            state_q <= S_POLL;  // service
          end
        end
        // one byte write per pass until the shadow is zero
        S_STOP: begin
          low_supply_irq_mask <= 1'b1;
          dev_wr   <= 1'b1;
          dev_addr <= `LVC_DEV_CTRL_ADDR;
          ret_q    <= S_STOP;
          state_q  <= S_OP;
          if (cfg_q[`LVC_CFG_BYTESTOP] && (shadow_q != `LVC_BYTE_ZERO)) begin
            shadow_q  <= `LVC_BYTE_ZERO;
            dev_wdata <= `LVC_BYTE_ZERO;
          end else if (shadow_q[`LVC_DC_MODE]) begin
            shadow_q  <= shadow_q & ~(8'h01 << `LVC_DC_MODE);
            dev_wdata <= shadow_q & ~(8'h01 << `LVC_DC_MODE);
          end else if (shadow_q[`LVC_DC_ENABLE]) begin
            shadow_q  <= shadow_q & ~(8'h01 << `LVC_DC_ENABLE);
            dev_wdata <= shadow_q & ~(8'h01 << `LVC_DC_ENABLE);
          end else if (shadow_q[`LVC_DC_REF]) begin
            shadow_q  <= shadow_q & ~(8'h01 << `LVC_DC_REF);
            dev_wdata <= shadow_q & ~(8'h01 << `LVC_DC_REF);
          end else begin
            flag_q  <= 1'b0;  // detector off
            state_q <= S_IDLE;
          end
        end
        S_OP: begin
          // four-phase handshake with the device
          if (!op_phase_q) begin
            dev_req <= 1'b1;
            if (dev_req && ack_in) begin
              rd_q       <= rdat_s[15:8];
              dev_req    <= 1'b0;
              op_phase_q <= 1'b1;
            end
          end else if (!ack_in) begin
            op_phase_q <= 1'b0;
            state_q    <= ret_q;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule // lvc_host

// [lvc_host_assertions.sv]
`timescale 1ns/1ps
`include "lvc_consts.vh"
// port checks of the host controller
module lvc_host_assertions (
  // clock, reset
  input wire                   pclk,
  input wire                   presetn,
  // apb answer
  input wire                   psel,
  input wire                   penable,
  input wire [31:0]            prdata,
  input wire                   pready,
  input wire                   pslverr,
  // device side
  input wire                   dev_req,
  input wire                   dev_wr,
  input wire [`LVC_DEV_AW-1:0] dev_addr,
  input wire [7:0]             dev_wdata,
  input wire                   dev_ack,
  input wire                   low_supply_irq_mask,
  input wire                   irq_req_clear
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wc = dev_req & dev_wr & (dev_addr == `LVC_DEV_CTRL_ADDR); // control write
  wire wl = dev_req & dev_wr & (dev_addr == `LVC_DEV_LVL_ADDR);  // level write
  // apb answers after one wait state, for one cycle
  property p_rdy; psel && penable && !pready |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("prdata not zero");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr alone");
  // request held with its qualifiers until ack
  property p_hold; dev_req && !dev_ack |=> dev_req && $stable(dev_addr) && $stable(dev_wdata);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped early");
  // start and stop ordering, legal level byte
  property p_mask; $rose(dev_req) && wc && dev_wdata[7] |-> low_supply_irq_mask; endproperty
  a_mask: assert property (p_mask) else $error("enable while unmasked");
  property p_lvl; $rose(dev_req) && wl |-> dev_wdata[7:3] == 5'h0 && dev_wdata[2:0] != 3'h7;
  endproperty
  a_lvl: assert property (p_lvl) else $error("bad level byte");
  property p_mode; $rose(dev_req) && wc && !dev_wdata[7] |-> !dev_wdata[1]; endproperty
  a_mode: assert property (p_mode) else $error("mode kept past enable");
  property p_unmask; $fell(low_supply_irq_mask) |-> $past(irq_req_clear); endproperty
  a_unmask: assert property (p_unmask) else $error("unmask before clear");
  // main scenarios seen
  c_clr: cover property (irq_req_clear);
  c_err: cover property (pslverr);
  c_zero: cover property ($rose(dev_req) && wc && dev_wdata == 8'h00);
endmodule // lvc_host_assertions

bind lvc_host lvc_host_assertions u_lvc_host_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .dev_req(dev_req), .dev_wr(dev_wr),
  .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_ack(dev_ack),
  .low_supply_irq_mask(low_supply_irq_mask), .irq_req_clear(irq_req_clear));

// [lvc_dev_model.sv]
`timescale 1ns/1ps
`include "lvc_consts.vh"
// detector model: registers, comparator, byte bus slave
module lvc_dev_model #(
  parameter REF_WAIT = 20,
  parameter ON_WAIT  = 10
) (
  // clock, reset
  input  wire        pclk,
  input  wire        presetn,
  // byte bus
  input  wire        dev_req,
  input  wire        dev_wr,
  input  wire [15:0] dev_addr,
  input  wire [7:0]  dev_wdata,
  output reg         dev_ack,
  output reg  [7:0]  dev_rdata,
  // interrupt pins
  input  wire        low_supply_irq_mask,
  input  wire        irq_req_clear,
  output reg         low_supply_irq_request,
  // analog side, knobs, probes
  input  wire        supply_low,
  input  wire        power_on_clear,
  input  wire [2:0]  ack_dly,
  output reg  [7:0]  ctrl_q,
  output reg  [7:0]  level_q,
  output reg         rst_q,
  output reg         cause_q,
  output reg         err_q
);
  reg  [2:0]  cnt_q;                          // ack delay
  reg  [19:0] ref_q;                          // cycles reference on
  reg  [19:0] on_q;                           // cycles detector on
  wire        flag = ctrl_q[7] & supply_low;
  wire        ctl  = dev_addr == `LVC_DEV_CTRL_ADDR;
  wire        low  = ctrl_q[7] & ctrl_q[1] & supply_low;
  wire        take = dev_req & ~dev_ack & (cnt_q == ack_dly);
  wire [7:0]  w    = dev_wdata;
  // order, level and wait faults of the host
  wire bad = ~dev_wr ? ctl & ctrl_q[7] & (on_q < ON_WAIT) :
    ~ctl ? (w[7:3] != 5'h0) | (w[2:0] == 3'h7) :
    (ctrl_q[7] & ~w[7] & w[1]) | (ctrl_q[4] & ~w[4] & w[7]) |
    (~ctrl_q[7] & w[7] & ~low_supply_irq_mask) |
    (~ctrl_q[7] & w[7] & ~power_on_clear & (ref_q < REF_WAIT));
  // registers and handshake
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ctrl_q, level_q, dev_rdata} <= 24'h0;
      {rst_q, cause_q, err_q, dev_ack, low_supply_irq_request} <= 5'h0;
      {cnt_q, ref_q, on_q} <= 43'h0;
    end else begin
      rst_q <= low;
      if (low)
        cause_q <= 1'b1;
      if (flag & ~ctrl_q[1])
        low_supply_irq_request <= 1'b1;
      else if (irq_req_clear)
        low_supply_irq_request <= 1'b0;
      ref_q <= ctrl_q[4] ? ref_q + 20'h1 : 20'h0;
      on_q <= ctrl_q[7] ? on_q + 20'h1 : 20'h0;
      if (take & bad)
        err_q <= 1'b1;
      if (take) begin
        dev_ack <= 1'b1;
        cnt_q <= 3'h0;
        dev_rdata <= ctl ? {ctrl_q[7:1], flag} : level_q;
        if (dev_wr & ctl)
          ctrl_q <= {w[7:1], 1'b0};
        if (dev_wr & ~ctl)
          level_q <= w;
      end else if (dev_req & ~dev_ack)
        cnt_q <= cnt_q + 3'h1;
      else if (~dev_req & dev_ack)
        dev_ack <= 1'b0;
      else if (~dev_ack)
        dev_rdata <= ~dev_rdata; // idle: no stale data
    end
  end
endmodule // lvc_dev_model

// [lvc_host_tb.sv]
`timescale 1ns/1ps
`include "lvc_consts.vh"
// host controller against the detector model
module lvc_host_tb;
  localparam [11:0] cfg = `LVC_REG_CONFIG;
  localparam [11:0] cmd = `LVC_REG_COMMAND;
  localparam [11:0] sts = `LVC_REG_STATUS;
  reg         pclk, presetn, psel, penable, pwrite, supply_low, power_on_clear;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, seed, r;
  reg  [2:0]  ack_dly;
  reg  [7:0]  lvl;
  reg  [64:0] e, exp_q[$];  // {slverr, field mask, value}
  integer     errors, samples_checked, i;
  wire [31:0] prdata;
  wire        pready, pslverr, dev_req, dev_wr, dev_ack, mask, clr, irq, lrst, cause, serr;
  wire [15:0] dev_addr;
  wire [7:0]  dev_wdata, dev_rdata, ctrl, level;
  lvc_host #(.REF_WAIT_CYC(20), .ON_WAIT_CYC(10)) u_lvc_host (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dev_req(dev_req), .dev_wr(dev_wr),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_ack(dev_ack), .dev_rdata(dev_rdata),
    .low_supply_irq_mask(mask), .irq_req_clear(clr), .low_supply_irq_request(irq));
  lvc_dev_model u_lvc_dev_model (.pclk(pclk), .presetn(presetn), .dev_req(dev_req),
    .dev_wr(dev_wr), .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_ack(dev_ack),
    .dev_rdata(dev_rdata), .low_supply_irq_mask(mask), .irq_req_clear(clr),
    .low_supply_irq_request(irq), .supply_low(supply_low), .power_on_clear(power_on_clear), .ack_dly(ack_dly),
    .ctrl_q(ctrl), .level_q(level), .rst_q(lrst), .cause_q(cause), .err_q(serr));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // xorshift source
  function [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed;
  endfunction
  // compare and count
  task chk(input [32:0] g, input [32:0] x);
    samples_checked = samples_checked + 1;
    if (g !== x) begin
      errors = errors + 1;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  // one apb transfer, read data left in r
  task apb(input wr, input [11:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // read with a note for the monitor
  task rd(input [11:0] a, input s, input [31:0] m, input [31:0] x);
    exp_q.push_back({s, m, x});
    apb(1'b0, a, 32'h0);
  endtask
  // poll until idle or running; the watchdog ends a hang
  task wait_idle;
    r = 32'h1;
    while (r[1:0] !== 2'b00 && r[1:0] !== 2'b11) begin
      rd(sts, 1'b0, 32'h0, 32'h0);
    end
  endtask
  // read answers against oldest note
  always @(posedge pclk) begin
    if (pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk({pslverr, prdata & e[63:32]}, {e[64], e[31:0]});
    end
  end
  // verdict and end of run
  task stop_test;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard
  initial begin
    #200000;
    errors = errors + 1;
    stop_test;
  end
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, supply_low, power_on_clear} = 6'h00;
    {paddr, pwdata, ack_dly} = 47'h0;
    {errors, samples_checked} = 64'h0;
    seed = 32'h38;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(mask, 1'b1);
    chk(level, 8'h00);
    rd(cfg, 1'b0, 32'hff, 32'h0);
    rd(12'h00c, 1'b1, 32'h0, 32'h0);
    rd(cmd, 1'b0, 32'hffffffff, 32'h0);
    // interrupt mode, random level, slow device, supply low at first
    r = rnd();
    lvl = {6'h00, r[1:0]};
    ack_dly <= 3'h4;
    supply_low <= 1'b1;
    apb(1'b1, cfg, {24'h0, lvl});
    apb(1'b1, cmd, 32'h1);
    repeat (300) @(posedge pclk);
    supply_low <= 1'b0;
    wait_idle;
    chk({ctrl, level, mask}, {8'h90, lvl, 1'b0});
    // drop the event left by the start-up request before the dip
    repeat (60) @(posedge pclk);
    apb(1'b1, sts, 32'h10);
    rd(sts, 1'b0, 32'h10, 32'h0);
    // dip while running: request seen and cleared
    supply_low <= 1'b1;
    repeat (20) @(posedge pclk);
    supply_low <= 1'b0;
    repeat (120) @(posedge pclk);
    chk(irq, 1'b0);
    rd(sts, 1'b0, 32'h1a, 32'h12);
    apb(1'b1, sts, 32'h10);
    rd(sts, 1'b0, 32'h10, 32'h0);
    // bit-wise stop from interrupt mode
    apb(1'b1, cmd, 32'h2);
    wait_idle;
    chk({ctrl, mask}, {8'h00, 1'b1});
    // reset mode, clear circuit fitted, level 6, fast device
    ack_dly <= 3'h0;
    power_on_clear <= 1'b1;
    apb(1'b1, cfg, 32'h1e);
    apb(1'b1, cmd, 32'h1);
    wait_idle;
    chk({ctrl, level, lrst}, {8'h82, 8'h06, 1'b0});
    supply_low <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({lrst, cause, ctrl}, 10'h382);
    supply_low <= 1'b0;
    apb(1'b1, cfg, 32'h5e);
    apb(1'b1, cmd, 32'h2);
    wait_idle;
    chk(ctrl, 8'h00);
    // refused: code 7, and code 4 with the 3.5 V clear
    for (i = 0; i < 2; i = i + 1) begin
      apb(1'b1, cfg, i ? 32'h24 : 32'h07);
      apb(1'b1, cmd, 32'h1);
      wait_idle;
      rd(sts, 1'b0, 32'h6, 32'h4);
    end
    chk(serr, 1'b0);
    stop_test;
  end
endmodule // lvc_host_tb
